// File: sbsram_pkg.sv
// Constants and types shared by the split-port burst-of-two SRAM core.
// Assumes nothing of its surroundings; pure definitions.
`default_nettype none
package sbsram_pkg;
  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int WORD_W     = 18;
  localparam int ADDR_W     = 18;   // 256K burst locations per word array.
  localparam int LANE_N     = 2;
  localparam int LANE0_LSB  = 0;
  localparam int LANE0_W    = 9;
  localparam int LANE1_LSB  = 9;
  localparam int LANE1_W    = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W     = 2 * WORD_W;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int REF_CLK_MHZ     = 50;
  localparam int ZCAL_PERIOD_CYC = 1024;  // Given in strobe cycles.
  localparam int ZCAL_CNT_W      = 10;
  localparam logic [ZCAL_CNT_W-1:0] ZCAL_LAST = 10'h3ff;
  localparam logic [WORD_W-1:0]     WORD_RST  = 18'h00000;
  typedef enum logic [1:0] {SBSRAM_RD_IDLE, SBSRAM_RD_WAIT, SBSRAM_RD_LO, SBSRAM_RD_HI} sbsram_rd_type;
endpackage : sbsram_pkg
`default_nettype wire

// File: sbsram_fifo.sv
// Small synchronous FIFO carrying write bursts toward the array.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sbsram_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rstn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready_out  = (count_r != DEPTH[PW:0]);
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  // Storage is left unreset; only pointers and count carry control state.
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  // Pointer and count bookkeeping.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : sbsram_fifo
`default_nettype wire

// File: sbsram_core.sv
// Split-port burst-of-two SRAM core: read port, write port, shared address.
// Assumes every pin input, strobes included, is asynchronous to ref_clk_in
// and is sampled through two flip-flops; strobe edges are found by sampling.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Accesses start on positive input strobe rise.
// - Each access is two 18-bit words.
// - Read select low latches read address.
// - Low read word follows next strobe rise.
// - High read word on negative output strobe.
// - Read bus floats after next output strobe.
// - Write select low captures first word.
// - Negative strobe latches address, second word.
// - Both words commit 36 bits to array.
// - Deselected write port ignores its inputs.
// - Lane selects sampled per data word.
// - Only asserted lanes change the array.
// - Lane 0 bits 8:0, lane 1 17:9.
// - Output strobes high at reset: single clock.
// - Read and write ports run independently.
// - Read of pending all-lane write returns forwarded data.
// - Port selects sampled on positive strobe only.
// - Deselecting one port leaves other untouched.
// - Impedance recalibration every 1024 strobe cycles.
// - Read data appears in cycle t+1.
// - Powers up deselected, read bus floating.
module sbsram_core (
  input  wire logic                           ref_clk_in,
  input  wire logic                           rstn_in,
  input  wire logic                           k_strobe_in,
  input  wire logic                           k_strobe_n_in,
  input  wire logic                           c_strobe_in,
  input  wire logic                           c_strobe_n_in,
  input  wire logic                           read_port_sel_n_in,
  input  wire logic                           write_port_sel_n_in,
  input  wire logic [1:0]                     byte_lane_sel_n_in,
  input  wire logic [sbsram_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [sbsram_pkg::WORD_W-1:0]  write_bus_in,
  output logic      [sbsram_pkg::WORD_W-1:0]  read_bus_out,
  output logic                                read_bus_oe_out,
  output logic                                zcal_pulse_out,
  output logic                                single_clock_out,
  output logic                                write_stall_out
);
  localparam int W = sbsram_pkg::WORD_W;
  localparam int A = sbsram_pkg::ADDR_W;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  localparam int SN = 6 + 2 + A + W;
  logic [SN-1:0] sync1_r;
  logic [SN-1:0] sync2_r;
  // Second stage only is read; the first is metastability guard.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      sync1_r <= {4'h7, 2'h3, 2'h3, {A{1'b0}}, {W{1'b0}}};   // Idle pin levels.
      sync2_r <= {4'h7, 2'h3, 2'h3, {A{1'b0}}, {W{1'b0}}};
    end else begin
      sync1_r <= {k_strobe_in, k_strobe_n_in, c_strobe_in, c_strobe_n_in, read_port_sel_n_in,
                  write_port_sel_n_in, byte_lane_sel_n_in, addr_in, write_bus_in};
      sync2_r <= sync1_r;
    end
  end
  logic         k_s, kn_s, c_s, cn_s, rps_n_s, wps_n_s;
  logic [1:0]   lane_n_s;
  logic [A-1:0] addr_s;
  logic [W-1:0] wdata_s;
  assign {k_s, kn_s, c_s, cn_s, rps_n_s, wps_n_s, lane_n_s, addr_s, wdata_s} = sync2_r;

  // ----------------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------------
  logic [3:0] strobe_d_r;
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      strobe_d_r <= 4'h7;   // Matches the idle strobes, so no false edge follows reset.
    end else begin
      strobe_d_r <= {k_s, kn_s, c_s, cn_s};
    end
  end
  logic single_clock_r;
  // Edges exist only while strobes toggle, so a stopped clock freezes all state but the write FIFO drain.
  wire k_rise  = k_s && !strobe_d_r[3];
  wire kn_rise = kn_s && !strobe_d_r[2];
  wire c_rise  = single_clock_r ? k_rise : (c_s && !strobe_d_r[1]);
  wire cn_rise = single_clock_r ? kn_rise : (cn_s && !strobe_d_r[0]);

  // Strap is caught once the synchroniser holds real pin levels rather than
  // its reset pattern, and only while the strobes are steady.
  logic       strap_done_r;
  logic [1:0] strap_wait_r;
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      strap_wait_r   <= 2'h0;
      strap_done_r   <= 1'b0;
      single_clock_r <= 1'b0;
    end else if (!strap_wait_r[1]) begin
      strap_wait_r <= strap_wait_r + 2'h1;
    end else if (!strap_done_r && strobe_d_r == {k_s, kn_s, c_s, cn_s}) begin
      strap_done_r   <= 1'b1;
      single_clock_r <= c_s && cn_s;
    end
  end
  assign single_clock_out = single_clock_r;

  // ----------------------------------------------------------------------
  // Arrays: two 256K x 18 halves, lower and upper burst word
  // ----------------------------------------------------------------------
  logic [W-1:0] arr_lo_r [2**A];
  logic [W-1:0] arr_hi_r [2**A];

  // ----------------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------------
  logic         wr_armed_r;
  logic [W-1:0] wr_lo_r;
  logic [1:0]   wr_lo_en_r;
  logic [W-1:0] fwd_lo_r, fwd_hi_r;
  logic [A-1:0] fwd_addr_r;
  logic         fwd_valid_r;
  logic         f_in_valid, f_in_ready, f_out_valid;
  logic [2*W+2*2+A-1:0] f_in_data, f_out_data;

  // Select is taken at positive strobe only; first word and lanes go with it.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wr_armed_r <= 1'b0;
      wr_lo_r    <= sbsram_pkg::WORD_RST;
      wr_lo_en_r <= 2'h0;
    end else if (k_rise) begin
      wr_armed_r <= !wps_n_s;
      if (!wps_n_s) begin
        wr_lo_r    <= wdata_s;
        wr_lo_en_r <= ~lane_n_s;
      end
    end else if (kn_rise) begin
      wr_armed_r <= 1'b0;
    end
  end

  // Negative strobe completes the burst and hands it to the FIFO.
  assign f_in_valid = kn_rise && wr_armed_r;
  assign f_in_data  = {addr_s, ~lane_n_s, wdata_s, wr_lo_en_r, wr_lo_r};

  // Keep the last burst visible for collision forwarding; valid only when every lane of both words is asserted.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      fwd_valid_r <= 1'b0;
      fwd_addr_r  <= '0;
      fwd_lo_r    <= sbsram_pkg::WORD_RST;
      fwd_hi_r    <= sbsram_pkg::WORD_RST;
    end else if (f_in_valid) begin
      fwd_valid_r <= (&wr_lo_en_r) && (&(~lane_n_s));
      fwd_addr_r  <= addr_s;
      fwd_lo_r    <= wr_lo_r;
      fwd_hi_r    <= wdata_s;
    end else if (k_rise && !wr_armed_r && wps_n_s) begin
      fwd_valid_r <= fwd_valid_r;
    end
  end

  sbsram_fifo #(
    .WIDTH (2*W+4+A),
    .DEPTH (sbsram_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk_in    (ref_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (f_in_valid),
    .in_ready_out  (f_in_ready),
    .in_data_in    (f_in_data),
    .out_valid_out (f_out_valid),
    .out_ready_in  (1'b1),
    .out_data_out  (f_out_data)
  );

  // Commit one burst per cycle, lane by lane; deasserted lanes keep old data.
  logic [A-1:0] c_addr;
  logic [1:0]   c_hi_en, c_lo_en;
  logic [W-1:0] c_hi, c_lo;
  assign {c_addr, c_hi_en, c_hi, c_lo_en, c_lo} = f_out_data;
  localparam int LSB [2] = '{sbsram_pkg::LANE0_LSB, sbsram_pkg::LANE1_LSB};
  wire  [W-1:0] lo_merge;
  wire  [W-1:0] hi_merge;
  genvar g;
  generate
    for (g = 0; g < sbsram_pkg::LANE_N; g++) begin : g_lane
      assign lo_merge[LSB[g] +: 9] = c_lo_en[g] ? c_lo[LSB[g] +: 9] : arr_lo_r[c_addr][LSB[g] +: 9];
      assign hi_merge[LSB[g] +: 9] = c_hi_en[g] ? c_hi[LSB[g] +: 9] : arr_hi_r[c_addr][LSB[g] +: 9];
    end
  endgenerate

  // One writer per array: lanes are merged above, so no word has two processes.
  always_ff @(posedge ref_clk_in) begin
    if (f_out_valid) begin
      arr_lo_r[c_addr] <= lo_merge;
      arr_hi_r[c_addr] <= hi_merge;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      write_stall_out <= 1'b0;
    end else begin
      write_stall_out <= !f_in_ready;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  sbsram_pkg::sbsram_rd_type rd_st_r;
  logic [A-1:0] rd_addr_r;
  logic [W-1:0] rd_hi_r;
  logic         rd_next_r;
  wire          fwd_hit = fwd_valid_r && (fwd_addr_r == rd_addr_r);
  // Address latched at select; data leaves one strobe cycle later.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rd_st_r         <= sbsram_pkg::SBSRAM_RD_IDLE;
      rd_addr_r       <= '0;
      rd_next_r       <= 1'b0;
      rd_hi_r         <= sbsram_pkg::WORD_RST;
      read_bus_out    <= sbsram_pkg::WORD_RST;
      read_bus_oe_out <= 1'b0;
    end else begin
      if (k_rise) begin
        rd_next_r <= !rps_n_s;
        if (!rps_n_s) begin
          rd_addr_r <= addr_s;
        end
      end
      case (rd_st_r)
        sbsram_pkg::SBSRAM_RD_IDLE: begin
          if (k_rise && !rps_n_s) begin
            rd_st_r <= sbsram_pkg::SBSRAM_RD_WAIT;
          end
        end
        sbsram_pkg::SBSRAM_RD_WAIT: begin
          if (c_rise) begin
            read_bus_oe_out <= 1'b1;
            read_bus_out    <= fwd_hit ? fwd_lo_r : arr_lo_r[rd_addr_r];
            rd_hi_r         <= fwd_hit ? fwd_hi_r : arr_hi_r[rd_addr_r];
            rd_st_r         <= sbsram_pkg::SBSRAM_RD_LO;
          end
        end
        sbsram_pkg::SBSRAM_RD_LO: begin
          if (cn_rise) begin
            read_bus_out <= rd_hi_r;
            rd_st_r      <= sbsram_pkg::SBSRAM_RD_HI;
          end
        end
        sbsram_pkg::SBSRAM_RD_HI: begin
          if (c_rise) begin
            if (rd_next_r) begin   // Back-to-back read keeps the bus driven.
              read_bus_out <= fwd_hit ? fwd_lo_r : arr_lo_r[rd_addr_r];
              rd_hi_r      <= fwd_hit ? fwd_hi_r : arr_hi_r[rd_addr_r];
              rd_st_r      <= sbsram_pkg::SBSRAM_RD_LO;
            end else begin
              read_bus_oe_out <= 1'b0;
              // A read selected on this same strobe edge must not be lost.
              rd_st_r         <= (k_rise && !rps_n_s) ? sbsram_pkg::SBSRAM_RD_WAIT : sbsram_pkg::SBSRAM_RD_IDLE;
            end
          end
        end
        default: rd_st_r <= sbsram_pkg::SBSRAM_RD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Impedance recalibration timer
  // ----------------------------------------------------------------------
  logic [sbsram_pkg::ZCAL_CNT_W-1:0] zcal_cnt_r;
  // Counts positive strobe cycles so a stopped clock also pauses tuning.
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      zcal_cnt_r     <= '0;
      zcal_pulse_out <= 1'b0;
    end else begin
      zcal_pulse_out <= k_rise && (zcal_cnt_r == sbsram_pkg::ZCAL_LAST);
      if (k_rise) begin
        zcal_cnt_r <= zcal_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  float_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    rd_st_r == sbsram_pkg::SBSRAM_RD_IDLE |=> !read_bus_oe_out || $past(c_rise))
    else $error("Read bus driven while idle.");
  rd_start_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (rd_st_r == sbsram_pkg::SBSRAM_RD_IDLE && k_rise && !rps_n_s) |=> rd_st_r == sbsram_pkg::SBSRAM_RD_WAIT)
    else $error("Read did not start on select.");
  no_start_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (k_rise && wps_n_s) |=> !wr_armed_r)
    else $error("Write armed while deselected.");
  wr_push_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    f_in_valid |=> f_out_valid && c_addr == $past(addr_s))
    else $error("Write burst lost its address.");
  hold_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (!k_rise && !kn_rise && !c_rise && !cn_rise) |=> $stable(read_bus_out))
    else $error("Read bus changed without strobe.");
  hi_word_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (rd_st_r == sbsram_pkg::SBSRAM_RD_LO && cn_rise) |=> read_bus_out == $past(rd_hi_r))
    else $error("High word not placed.");
  oe_on_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    (rd_st_r == sbsram_pkg::SBSRAM_RD_WAIT && c_rise) |=> read_bus_oe_out)
    else $error("Low word not driven.");
  zcal_a: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
    zcal_pulse_out |-> $past(zcal_cnt_r) == sbsram_pkg::ZCAL_LAST)
    else $error("Recalibration off period.");
endmodule : sbsram_core
`default_nettype wire

// File: sbsram_ctrl_model.sv
// Behavioural memory controller: makes the input strobes and drives the
// selects, lane selects, address and write data, one strobe period a call.
// Assumes ref_clk_in at 50 MHz; one strobe period is eight of its cycles.
`timescale 1ns/1ps
`default_nettype none
module sbsram_ctrl_model (
  input  wire logic        ref_clk_in,
  input  wire logic [17:0] read_bus_in,
  input  wire logic        oe_in,
  output logic             k_out,
  output logic             k_n_out,
  output logic             c_out,
  output logic             c_n_out,
  output logic             read_port_sel_n_out,
  output logic             write_port_sel_n_out,
  output logic [1:0]       byte_lane_sel_n_out,
  output logic [17:0]      addr_out,
  output logic [17:0]      data_out
);
  // --------------------------------------------------------------------
  // Pin state and samples of the read bus
  // --------------------------------------------------------------------
  logic [17:0] lo_s;
  logic [17:0] hi_s;
  logic        oe_s;
  // Output strobes stay high for good, so the core straps to one clock pair.
  initial begin
    {k_out, k_n_out, c_out, c_n_out} = 4'h7;
    {read_port_sel_n_out, write_port_sel_n_out, byte_lane_sel_n_out} = 4'hf;
    addr_out = 18'h00000;
    data_out = 18'h00000;
  end
  // --------------------------------------------------------------------
  // One strobe period: inputs change half a phase away from each edge
  // --------------------------------------------------------------------
  // Late moves the read select so that it is low only around the negative
  // strobe rise. An idle write bus shows the inverse of its last value, so a
  // core that samples it while deselected cannot be saved by stale data.
  task automatic cycle(input bit rd, input bit wr, input bit late, input logic [17:0] ra,
                       input logic [17:0] wa, input logic [17:0] d0, input logic [17:0] d1,
                       input logic [1:0] l0, input logic [1:0] l1);
    @(negedge ref_clk_in);
    lo_s = read_bus_in;
    oe_s = oe_in;
    read_port_sel_n_out  = late | ~rd;
    write_port_sel_n_out = ~wr;
    addr_out = ra;
    data_out = wr ? d0 : ~data_out;
    byte_lane_sel_n_out = l0;
    repeat (2) @(negedge ref_clk_in);
    k_out   = 1'h1;
    k_n_out = 1'h0;
    repeat (2) @(negedge ref_clk_in);
    hi_s = read_bus_in;
    if (late) begin
      read_port_sel_n_out = ~rd;
    end
    addr_out = wa;
    data_out = wr ? d1 : ~data_out;
    byte_lane_sel_n_out = l1;
    repeat (2) @(negedge ref_clk_in);
    k_out   = 1'h0;
    k_n_out = 1'h1;
    @(negedge ref_clk_in);
  endtask : cycle
endmodule : sbsram_ctrl_model
`default_nettype wire

// File: sbsram_tb.sv
// Self-checking bench for the SRAM core and its write FIFO.
// Assumes the controller model in its own file; inputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        ref_clk_in;
  logic        rstn_in;
  logic        k, k_n, c, c_n, rd_sel_n, wr_sel_n, oe, zcal, single, stall;
  logic [1:0]  lanes_n;
  logic [17:0] addr, wdata, rdata;
  int          miscompares = 0;
  int          check_count = 0;
  int          kcnt = 0;
  int          zp[$];
  // --------------------------------------------------------------------
  // Clock, instances and a log of strobe counts at each tuning pulse
  // --------------------------------------------------------------------
  initial begin
    ref_clk_in = 1'h0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  sbsram_core dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .k_strobe_in(k), .k_strobe_n_in(k_n),
    .c_strobe_in(c), .c_strobe_n_in(c_n), .read_port_sel_n_in(rd_sel_n), .write_port_sel_n_in(wr_sel_n),
    .byte_lane_sel_n_in(lanes_n), .addr_in(addr), .write_bus_in(wdata), .read_bus_out(rdata),
    .read_bus_oe_out(oe), .zcal_pulse_out(zcal), .single_clock_out(single), .write_stall_out(stall));
  sbsram_ctrl_model ctrl (.ref_clk_in(ref_clk_in), .read_bus_in(rdata), .oe_in(oe), .k_out(k),
    .k_n_out(k_n), .c_out(c), .c_n_out(c_n), .read_port_sel_n_out(rd_sel_n),
    .write_port_sel_n_out(wr_sel_n), .byte_lane_sel_n_out(lanes_n), .addr_out(addr), .data_out(wdata));
  // A pulse held two cycles logs twice and shows up as a zero gap.
  always @(posedge k) kcnt++;
  always @(posedge ref_clk_in) if (zcal === 1'h1) zp.push_back(kcnt);
  // --------------------------------------------------------------------
  // Compare, stimulus and closing tasks
  // --------------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [35:0] e, input logic [35:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_word
  task automatic chk_bit(input string nm, input logic e, input logic s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", nm, e, s);
    end
  endtask : chk_bit
  task automatic chk_num(input string nm, input int e, input int s);
    check_count++;
    if (s != e) begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", nm, e, s);
    end
  endtask : chk_num
  // A read issued in one call shows its burst in the samples two calls on.
  task automatic cyc(input bit rd, input bit wr, input logic [17:0] ra, input logic [17:0] wa = 18'h0,
                     input logic [17:0] d0 = 18'h0, input logic [17:0] d1 = 18'h0,
                     input logic [1:0] l0 = 2'h0, input logic [1:0] l1 = 2'h0);
    ctrl.cycle(rd, wr, 1'h0, ra, wa, d0, d1, l0, l1);
  endtask : cyc
  task automatic chk_burst(input string nm, input logic [17:0] lo, input logic [17:0] hi);
    chk_word({nm, "_lo"}, lo, ctrl.lo_s);
    chk_word({nm, "_hi"}, hi, ctrl.hi_s);
    chk_bit({nm, "_oe"}, 1'h1, ctrl.oe_s);
  endtask : chk_burst
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_basic();
    chk_bit("oe_reset", 1'h0, oe);
    chk_word("rdata_reset", 18'h0, rdata);
    chk_bit("single_clock", 1'h1, single);
    cyc(1'h0, 1'h1, 18'h0, 18'h00010, 18'h12345, 18'h2abcd);
    cyc(1'h0, 1'h0, 18'h0);
    cyc(1'h1, 1'h0, 18'h00010);
    cyc(1'h0, 1'h0, 18'h0);
    cyc(1'h0, 1'h0, 18'h0);
    chk_burst("basic", 18'h12345, 18'h2abcd);
    cyc(1'h0, 1'h0, 18'h0);
    chk_bit("oe_float", 1'h0, ctrl.oe_s);
    $display("test basic done");
  endtask : t_basic
  // Lane selects differ between the two words; an all-off write follows.
  task automatic t_lanes();
    cyc(1'h0, 1'h1, 18'h0, 18'h00020, 18'h15555, 18'h0aaaa);
    cyc(1'h0, 1'h1, 18'h0, 18'h00020, 18'h3ffff, 18'h3ffff, 2'h2, 2'h1);
    cyc(1'h0, 1'h1, 18'h0, 18'h00020, 18'h00000, 18'h00000, 2'h3, 2'h3);
    cyc(1'h0, 1'h0, 18'h0);
    cyc(1'h1, 1'h0, 18'h00020);
    cyc(1'h0, 1'h0, 18'h0);
    cyc(1'h0, 1'h0, 18'h0);
    chk_burst("lanes", (18'h15555 & 18'h3fe00) | 18'h001ff, 18'h3fe00 | (18'h0aaaa & 18'h001ff));
    $display("test lanes done");
  endtask : t_lanes
  // Reads chase the write of the previous strobe cycle, back to back.
  task automatic t_conc();
    cyc(1'h0, 1'h1, 18'h0, 18'h00030, 18'h01111, 18'h02222);
    cyc(1'h1, 1'h1, 18'h00030, 18'h00031, 18'h03333, 18'h04444);
    cyc(1'h1, 1'h0, 18'h00031);
    cyc(1'h0, 1'h0, 18'h0);
    chk_burst("fwd_a", 18'h01111, 18'h02222);
    cyc(1'h0, 1'h0, 18'h0);
    chk_burst("fwd_b", 18'h03333, 18'h04444);
    $display("test concurrent done");
  endtask : t_conc
  // Deselected write with live data, then a read select low only off the edge.
  task automatic t_desel();
    cyc(1'h0, 1'h0, 18'h00010, 18'h00010);
    ctrl.cycle(1'h1, 1'h0, 1'h1, 18'h00010, 18'h00010, 18'h0, 18'h0, 2'h0, 2'h0);
    cyc(1'h0, 1'h0, 18'h0);
    cyc(1'h0, 1'h0, 18'h0);
    chk_bit("late_sel_oe", 1'h0, ctrl.oe_s);
    cyc(1'h1, 1'h0, 18'h00010);
    cyc(1'h0, 1'h0, 18'h0);
    cyc(1'h0, 1'h0, 18'h0);
    chk_burst("desel", 18'h12345, 18'h2abcd);
    $display("test deselect done");
  endtask : t_desel
  // Strobes stop while a read waits for its burst; the bus keeps the last
  // word of the previous read and the burst follows once strobes resume.
  task automatic t_stop();
    cyc(1'h1, 1'h0, 18'h00030);
    repeat (40) @(negedge ref_clk_in);
    chk_word("stopped_data", 18'h2abcd, rdata);
    chk_bit("stopped_oe", 1'h0, oe);
    cyc(1'h0, 1'h0, 18'h0);
    cyc(1'h0, 1'h0, 18'h0);
    chk_burst("restart", 18'h01111, 18'h02222);
    $display("test stopped clock done");
  endtask : t_stop
  // Eight write bursts back to back through the write FIFO, then two reads
  // where the second is selected on the edge that ends the first burst.
  task automatic t_fifo();
    for (int i = 0; i < 8; i++) begin
      cyc(1'h0, 1'h1, 18'h0, 18'h00040 + 18'(i), 18'h00100 + 18'(i), 18'h00200 + 18'(i));
      chk_bit("write_stall_burst", 1'h0, stall);
    end
    chk_bit("fifo_oe_idle", 1'h0, ctrl.oe_s);
    cyc(1'h1, 1'h0, 18'h00040);
    cyc(1'h0, 1'h0, 18'h0);
    cyc(1'h1, 1'h0, 18'h00047);
    chk_burst("fifo_first", 18'h00100, 18'h00200);
    cyc(1'h0, 1'h0, 18'h0);
    chk_bit("fifo_gap_oe", 1'h0, ctrl.oe_s);
    cyc(1'h0, 1'h0, 18'h0);
    chk_burst("fifo_last", 18'h00107, 18'h00207);
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_zcal();
    repeat (2100) cyc(1'h0, 1'h0, 18'h0);
    while (zp.size() < 2) zp.push_back(0);
    chk_num("zcal_gap", 1024, zp[zp.size()-1] - zp[zp.size()-2]);
    chk_bit("write_stall", 1'h0, stall);
    $display("test recalibration done");
  endtask : t_zcal
  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    rstn_in = 1'h0;
    repeat (4) @(negedge ref_clk_in);
    rstn_in = 1'h1;
    repeat (4) @(negedge ref_clk_in);
    t_basic();
    t_lanes();
    t_conc();
    t_desel();
    t_stop();
    t_fifo();
    t_zcal();
    stop_test();
  end
  // The whole run needs about 344 us; about twice that means a hang.
  initial begin
    #700000;
    miscompares++;
    $display("watchdog expired");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
